//--- core/cmsl_defs.svh
// timing and encoding constants for the controller mode sequencer
`ifndef CMSL_DEFS_SVH
`define CMSL_DEFS_SVH

`define CMSL_CLK_HZ 25000000
`define CMSL_RESET_SHOW_MS 100
`define CMSL_RESET_SHOW_CYC ((`CMSL_CLK_HZ / 1000) * `CMSL_RESET_SHOW_MS)
`define CMSL_TICK_HZ 1000
`define CMSL_TICK_DIV (`CMSL_CLK_HZ / `CMSL_TICK_HZ)
`define CMSL_HALF_5HZ_MS 100
`define CMSL_HALF_2HZ_MS 250
`define CMSL_HALF_05HZ_MS 1000
`define CMSL_SEG7_BITS 35
`define CMSL_SEG14_BITS 42
`define CMSL_LEGEND_BITS 8
`define CMSL_BTN_A_BIT 0
`define CMSL_BTN_B_BIT 1
`define CMSL_BTN_C_BIT 2

`endif

//--- core/cmsl_pkg.sv
// types shared by the controller mode sequencer
package cmsl_pkg;

    typedef enum logic [2:0] {
        CMSL_MODE_RESET,
        CMSL_MODE_RUN,
        CMSL_MODE_STOP,
        CMSL_MODE_FATAL,
        CMSL_MODE_NO_OS
    } cmsl_mode_t;

    typedef enum logic [1:0] {
        CMSL_NET_PREPARED,
        CMSL_NET_PREOP,
        CMSL_NET_OPERATIONAL
    } cmsl_net_t;

    typedef struct packed {
        logic red;
        logic green;
    } cmsl_lamp_t;

    typedef struct packed {
        logic run_cmd;
        logic stop_cmd;
        logic nmt_test_mode;
        logic nmt_preop_req;
        logic nmt_op_req;
        logic nmt_prepared_req;
    } cmsl_req_t;

    typedef struct packed {
        logic [34:0] seg7;
        logic [41:0] seg14;
        logic [7:0] legend;
    } cmsl_lcd_t;

endpackage

//--- core/cmsl_mode_seq.sv
// operating mode sequencer with status lamp encoder and operator inputs
`timescale 1ns/100ps
`include "cmsl_defs.svh"

module cmsl_mode_seq
    import cmsl_pkg::*;
#(
    parameter int TICK_DIV = `CMSL_TICK_DIV,
    parameter int SHOW_CYC = `CMSL_RESET_SHOW_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic os_present,
    input wire logic app_present,
    input wire logic init_done,
    input wire logic fatal_error,
    input wire logic run_error,
    input wire cmsl_req_t mode_req,
    input wire logic program_release_switch,
    input wire logic load_request,
    input wire logic connect_request,
    input wire logic [3:0] rotary_selector,
    input wire logic push_button_a,
    input wire logic push_button_b,
    input wire logic push_button_c,
    input wire logic segment_write_call,
    input wire logic text_write_call,
    input wire cmsl_lcd_t lcd_bits,
    output cmsl_lamp_t status_lamp_pair,
    output cmsl_mode_t mode,
    output cmsl_net_t net_state,
    output logic app_execute,
    output logic pdo_enable,
    output logic net_preop_flag,
    output logic program_write_protect,
    output logic load_accept,
    output logic connect_accept,
    output logic [7:0] selector_byte,
    output logic [2:0] button_bits,
    output cmsl_lcd_t lcd_drive
);

    // ****************************************************
    // reset release
    // ****************************************************
    logic rst_meta_q;
    logic rst_n_q;

    default clocking cmsl_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n_q);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************************
    // system tick and flash timers
    // ****************************************************
    localparam int TICK_MAX = TICK_DIV - 1;
    localparam int SHOW_MAX = SHOW_CYC - 1;
    localparam int H5 = `CMSL_HALF_5HZ_MS - 1;
    localparam int H2 = `CMSL_HALF_2HZ_MS - 1;
    localparam int H05 = `CMSL_HALF_05HZ_MS - 1;

    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [9:0] flash_cnt_q, flash_cnt_d;
    logic phase_q, phase_d;
    logic [9:0] half_len;
    logic pattern_change;
    cmsl_mode_t mode_q, mode_d;
    cmsl_net_t net_q, net_d;

    always_comb
    begin
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + 16'h0001;
        if (tick_cnt_q == TICK_MAX[15:0])
        begin
            tick_cnt_d = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_comb
    begin
        half_len = H05[9:0];
        if (mode_q == CMSL_MODE_NO_OS)
        begin
            half_len = H5[9:0];
        end
        else if (net_q == CMSL_NET_OPERATIONAL)
        begin
            half_len = H2[9:0];
        end
    end

    // a changed pattern restarts its period with the lamp lit
    always_comb
    begin
        flash_cnt_d = flash_cnt_q;
        phase_d = phase_q;
        if (pattern_change)
        begin
            flash_cnt_d = 10'h000;
            phase_d = 1'b1;
        end
        else if (tick_q)
        begin
            if (flash_cnt_q >= half_len)
            begin
                flash_cnt_d = 10'h000;
                phase_d = ~phase_q;
            end
            else
            begin
                flash_cnt_d = flash_cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            flash_cnt_q <= 10'h000;
            phase_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            flash_cnt_q <= flash_cnt_d;
            phase_q <= phase_d;
        end
    end

    // ****************************************************
    // mode sequencer
    // ****************************************************
    logic [21:0] show_cnt_q, show_cnt_d;
    logic go_run;
    logic go_stop;

    assign go_run = mode_req.run_cmd || (mode_req.nmt_test_mode &&
        (mode_req.nmt_preop_req || mode_req.nmt_op_req));
    assign go_stop = mode_req.stop_cmd ||
        (mode_req.nmt_test_mode && mode_req.nmt_prepared_req);
    assign pattern_change = (mode_d != mode_q) || (net_d != net_q);

    always_comb
    begin
        mode_d = mode_q;
        net_d = net_q;
        show_cnt_d = show_cnt_q;
        unique case (mode_q)
            CMSL_MODE_RESET:
            begin
                if (!os_present)
                begin
                    mode_d = CMSL_MODE_NO_OS;
                end
                else if (fatal_error)
                begin
                    mode_d = CMSL_MODE_FATAL;
                end
                else if (show_cnt_q != SHOW_MAX[21:0])
                begin
                    show_cnt_d = show_cnt_q + 22'h000001;
                end
                else if (init_done)
                begin
                    if (app_present)
                    begin
                        mode_d = CMSL_MODE_RUN;
                        net_d = CMSL_NET_PREOP;
                    end
                    else
                    begin
                        mode_d = CMSL_MODE_STOP;
                        net_d = CMSL_NET_PREPARED;
                    end
                end
            end
            CMSL_MODE_RUN:
            begin
                if (fatal_error)
                begin
                    mode_d = CMSL_MODE_FATAL;
                end
                else if (go_stop)
                begin
                    mode_d = CMSL_MODE_STOP;
                    net_d = CMSL_NET_PREPARED;
                end
                else if (mode_req.nmt_test_mode && mode_req.nmt_op_req)
                begin
                    net_d = CMSL_NET_OPERATIONAL;
                end
                else if (mode_req.nmt_test_mode && mode_req.nmt_preop_req)
                begin
                    net_d = CMSL_NET_PREOP;
                end
            end
            CMSL_MODE_STOP:
            begin
                if (fatal_error)
                begin
                    mode_d = CMSL_MODE_FATAL;
                end
                else if (go_run)
                begin
                    mode_d = CMSL_MODE_RUN;
                    net_d = (mode_req.nmt_test_mode && mode_req.nmt_op_req)
                        ? CMSL_NET_OPERATIONAL : CMSL_NET_PREOP;
                end
            end
            CMSL_MODE_FATAL:
            begin
                mode_d = CMSL_MODE_FATAL;
            end
            CMSL_MODE_NO_OS:
            begin
                mode_d = CMSL_MODE_NO_OS;
            end
            default:
            begin
                mode_d = CMSL_MODE_FATAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mode_q <= CMSL_MODE_RESET;
            net_q <= CMSL_NET_PREPARED;
            show_cnt_q <= 22'h000000;
        end
        else
        begin
            mode_q <= mode_d;
            net_q <= net_d;
            show_cnt_q <= show_cnt_d;
        end
    end

    // ****************************************************
    // registered outputs
    // ****************************************************
    cmsl_lamp_t lamp_d;
    logic [2:0] btn_d;

    always_comb
    begin
        lamp_d = '{red: 1'b0, green: 1'b0};
        unique case (mode_d)
            CMSL_MODE_RESET:
                lamp_d = '{red: 1'b1, green: 1'b1};
            CMSL_MODE_NO_OS:
                lamp_d.green = phase_d;
            CMSL_MODE_RUN:
            begin
                if (run_error)
                begin
                    lamp_d.red = phase_d;
                end
                else
                begin
                    lamp_d.green = phase_d;
                end
            end
            CMSL_MODE_STOP:
                lamp_d.green = 1'b1;
            CMSL_MODE_FATAL:
                lamp_d.red = 1'b1;
            default:
                lamp_d.red = 1'b1;
        endcase
        btn_d = 3'h0;
        btn_d[`CMSL_BTN_A_BIT] = push_button_a;
        btn_d[`CMSL_BTN_B_BIT] = push_button_b;
        btn_d[`CMSL_BTN_C_BIT] = push_button_c;
    end

    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            status_lamp_pair <= '{red: 1'b1, green: 1'b1};
            mode <= CMSL_MODE_RESET;
            net_state <= CMSL_NET_PREPARED;
            app_execute <= 1'b0;
            pdo_enable <= 1'b0;
            net_preop_flag <= 1'b0;
            program_write_protect <= 1'b1;
            load_accept <= 1'b0;
            connect_accept <= 1'b0;
            selector_byte <= 8'h00;
            button_bits <= 3'h0;
            lcd_drive <= '0;
        end
        else
        begin
            status_lamp_pair <= lamp_d;
            mode <= mode_d;
            net_state <= net_d;
            app_execute <= (mode_d == CMSL_MODE_RUN);
            pdo_enable <= (mode_d == CMSL_MODE_RUN) &&
                (net_d == CMSL_NET_OPERATIONAL);
            net_preop_flag <= (net_d == CMSL_NET_PREOP);
            program_write_protect <= !program_release_switch;
            load_accept <= load_request && program_release_switch;
            connect_accept <= connect_request &&
                program_release_switch;
            selector_byte <= {4'h0, rotary_selector};
            button_bits <= btn_d;
            if (segment_write_call || text_write_call)
            begin
                lcd_drive <= lcd_bits;
            end
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    sequence s_fatal_seen;
        mode == CMSL_MODE_FATAL;
    endsequence

    a_fatal_held: assert property (
        s_fatal_seen |=> mode == CMSL_MODE_FATAL)
        else $error("fatal mode left without reset");
    a_fatal_lamp: assert property (
        mode == CMSL_MODE_FATAL |-> status_lamp_pair == 2'b10)
        else $error("fatal lamp not steady red");
    a_stop_lamp: assert property (
        mode == CMSL_MODE_STOP |-> status_lamp_pair == 2'b01)
        else $error("stop lamp not steady green");
    a_exec_run: assert property (
        app_execute == (mode == CMSL_MODE_RUN))
        else $error("execution outside run");
    a_pdo_gate: assert property (
        pdo_enable == (mode == CMSL_MODE_RUN &&
        net_state == CMSL_NET_OPERATIONAL))
        else $error("pdo enable does not follow operational run");
    a_preop_flag: assert property (
        net_preop_flag == (net_state == CMSL_NET_PREOP))
        else $error("preop flag mismatch");
    a_stop_to_run: assert property (
        mode_q == CMSL_MODE_STOP && mode_req.run_cmd && !fatal_error
        |=> mode == CMSL_MODE_RUN)
        else $error("run command ignored in stop");
    a_run_to_stop: assert property (
        mode_q == CMSL_MODE_RUN && mode_req.stop_cmd && !fatal_error
        |=> mode == CMSL_MODE_STOP)
        else $error("stop command ignored in run");
    a_lock_protect: assert property (
        !program_release_switch |=> program_write_protect && !load_accept)
        else $error("locked switch did not protect");
    a_noos_flash: assert property (
        mode == CMSL_MODE_NO_OS |-> !status_lamp_pair.red)
        else $error("red lit without operating system");

endmodule

//--- tb/cmsl_partner.sv
// model of the programming system and network master
`timescale 1ns/100ps
module cmsl_partner
    import cmsl_pkg::*;
(
    input wire logic ref_clk,
    output cmsl_req_t mode_req,
    output logic program_release_switch,
    output logic load_request,
    output logic connect_request
);
    initial
    begin
        mode_req = '0;
        program_release_switch = 1'b0;
        load_request = 1'b0;
        connect_request = 1'b0;
    end

    // one-cycle request pulse; nmt requests without the test mode bit are ignored
    task automatic send(input cmsl_req_t r);
    begin
        @(posedge ref_clk);
        #2;
        mode_req = r;
        @(posedge ref_clk);
        #2;
        mode_req = '0;
    end
    endtask

    // switch position, then load and connect attempts
    task automatic set_prog(input logic sw, input logic ld, input logic cn);
    begin
        @(posedge ref_clk);
        #2;
        program_release_switch = sw;
        load_request = ld;
        connect_request = cn;
    end
    endtask
endmodule

//--- tb/controller_mode_status_led_tb.sv
// self-checking bench for the controller mode sequencer
`timescale 1ns/100ps
`include "cmsl_defs.svh"
module controller_mode_status_led_tb;
    import cmsl_pkg::*;
    typedef struct packed {
        cmsl_req_t req;
        logic err;
        cmsl_mode_t m;
        cmsl_net_t n;
        cmsl_lamp_t l;
        logic [2:0] o;
    } cmsl_row_t;
    // short tick and reset display keep the run small
    localparam int TB_TICK = 10;
    localparam int TB_SHOW = 100;
    localparam int H5_CYC = `CMSL_TICK_HZ / 10 * TB_TICK;
    localparam int H2_CYC = `CMSL_TICK_HZ / 4 * TB_TICK;
    localparam int H05_CYC = `CMSL_TICK_HZ * TB_TICK;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic os_present = 1'b1;
    logic app_present = 1'b1;
    logic init_done = 1'b1;
    logic fatal_error = 1'b0;
    logic run_error = 1'b0;
    logic [3:0] rotary_selector = 4'h0;
    logic [2:0] btn = 3'h0;
    logic seg_call = 1'b0;
    logic txt_call = 1'b0;
    cmsl_lcd_t lcd_bits = '0;
    cmsl_req_t mode_req;
    logic sw, ld, cn;
    cmsl_lamp_t lamp;
    cmsl_mode_t mode;
    cmsl_net_t net_state;
    logic app_execute, pdo_enable, net_preop_flag, wp, la, ca;
    logic [7:0] selector_byte;
    logic [2:0] button_bits;
    cmsl_lcd_t lcd_drive;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    cmsl_row_t rows [13];

    always #20 ref_clk = ~ref_clk;

    cmsl_partner partner (.ref_clk(ref_clk), .mode_req(mode_req),
        .program_release_switch(sw), .load_request(ld),
        .connect_request(cn));

    cmsl_mode_seq #(.TICK_DIV(TB_TICK), .SHOW_CYC(TB_SHOW)) dut (
        .ref_clk(ref_clk), .nrst(nrst),
        .os_present(os_present), .app_present(app_present),
        .init_done(init_done), .fatal_error(fatal_error),
        .run_error(run_error), .mode_req(mode_req),
        .program_release_switch(sw), .load_request(ld),
        .connect_request(cn), .rotary_selector(rotary_selector),
        .push_button_a(btn[0]), .push_button_b(btn[1]),
        .push_button_c(btn[2]), .segment_write_call(seg_call),
        .text_write_call(txt_call), .lcd_bits(lcd_bits),
        .status_lamp_pair(lamp), .mode(mode), .net_state(net_state),
        .app_execute(app_execute), .pdo_enable(pdo_enable),
        .net_preop_flag(net_preop_flag), .program_write_protect(wp),
        .load_accept(la), .connect_accept(ca),
        .selector_byte(selector_byte), .button_bits(button_bits),
        .lcd_drive(lcd_drive));

    task automatic check(input string what, input logic [84:0] seen,
        input logic [84:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    end
    endtask

    task automatic step(input int k);
    begin
        repeat (k) @(posedge ref_clk);
        #2;
    end
    endtask

    // cycles until the chosen lamp next changes level
    task automatic measure(input logic red, output int len);
        logic v;
    begin
        v = red ? lamp.red : lamp.green;
        len = 0;
        while ((red ? lamp.red : lamp.green) === v && len < 40000)
        begin
            step(1);
            len++;
        end
    end
    endtask

    task automatic close_out();
    begin
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    // about twice the cycles that all tests take
    initial
    begin
        #(64'd60000 * 40);
        fail_count++;
        close_out();
    end

    initial
    begin
        // req {run,stop,test,preop,op,prepared}, err, mode, net, lamp, outs
        rows[0] = {6'h0a, 1'b0, CMSL_MODE_RUN, CMSL_NET_OPERATIONAL, 2'h1, 3'h6};
        rows[1] = {6'h0c, 1'b1, CMSL_MODE_RUN, CMSL_NET_PREOP, 2'h2, 3'h5};
        rows[2] = {6'h01, 1'b1, CMSL_MODE_RUN, CMSL_NET_PREOP, 2'h2, 3'h5};
        rows[3] = {6'h09, 1'b0, CMSL_MODE_STOP, CMSL_NET_PREPARED, 2'h1, 3'h0};
        rows[4] = {6'h20, 1'b0, CMSL_MODE_RUN, CMSL_NET_PREOP, 2'h1, 3'h5};
        rows[5] = {6'h20, 1'b0, CMSL_MODE_RUN, CMSL_NET_PREOP, 2'h1, 3'h5};
        rows[6] = {6'h10, 1'b0, CMSL_MODE_STOP, CMSL_NET_PREPARED, 2'h1, 3'h0};
        rows[7] = {6'h10, 1'b0, CMSL_MODE_STOP, CMSL_NET_PREPARED, 2'h1, 3'h0};
        rows[8] = {6'h0c, 1'b0, CMSL_MODE_RUN, CMSL_NET_PREOP, 2'h1, 3'h5};
        rows[9] = {6'h0a, 1'b0, CMSL_MODE_RUN, CMSL_NET_OPERATIONAL, 2'h1, 3'h6};
        rows[10] = {6'h10, 1'b0, CMSL_MODE_STOP, CMSL_NET_PREPARED, 2'h1, 3'h0};
        rows[11] = {6'h0a, 1'b0, CMSL_MODE_RUN, CMSL_NET_OPERATIONAL, 2'h1, 3'h6};
        rows[12] = {6'h10, 1'b1, CMSL_MODE_STOP, CMSL_NET_PREPARED, 2'h1, 3'h0};
        step(8);
        check("reset lamps", lamp, 2'h3);
        check("reset mode", mode, CMSL_MODE_RESET);
        check("reset protect", wp, 1'b1);
        nrst = 1'b1;
        step(10);
        check("reset show lamps", {mode, lamp}, {CMSL_MODE_RESET,
            2'h3});
        n = 0;
        while (mode === CMSL_MODE_RESET && n < TB_SHOW + 100)
        begin
            step(1);
            n++;
        end
        check("autostart mode", mode, CMSL_MODE_RUN);
        check("autostart net", net_state, CMSL_NET_PREOP);
        check("autostart lamp", lamp, 2'h1);
        $display("test reset done");
        foreach (rows[i])
        begin
            run_error = rows[i].err;
            partner.send(rows[i].req);
            check("row", {mode, net_state, lamp, app_execute, pdo_enable,
                net_preop_flag}, {rows[i].m, rows[i].n, rows[i].l,
                rows[i].o});
        end
        run_error = 1'b0;
        step(200);
        check("stop steady lamp", lamp, 2'h1);
        $display("test mode rows done");
        for (int r = 0; r < 16; r++)
        begin
            rotary_selector = r[3:0];
            btn = r[2:0];
            step(2);
            check("selector", selector_byte, {4'h0, r[3:0]});
            check("buttons", button_bits, r[2:0]);
        end
        for (int s = 0; s < 2; s++)
        begin
            partner.set_prog(s[0], 1'b1, 1'b1);
            step(2);
            check("protect", wp, !s[0]);
            check("load", la, s[0]);
            check("connect", ca, s[0]);
        end
        lcd_bits = {5{17'h1a5c3}};
        seg_call = 1'b1;
        step(1);
        seg_call = 1'b0;
        lcd_bits = ~lcd_bits;
        step(2);
        check("lcd seg", lcd_drive, {5{17'h1a5c3}});
        txt_call = 1'b1;
        step(1);
        txt_call = 1'b0;
        step(1);
        check("text_write_call", lcd_drive, ~{5{17'h1a5c3}});
        $display("test operator done");
        partner.send(6'h20);
        measure(1'b0, n);
        check("0.5 hz first half", n > H05_CYC - TB_TICK && n <= H05_CYC,
            1'b1);
        measure(1'b0, n);
        check("0.5 hz half", n, H05_CYC);
        run_error = 1'b1;
        partner.send(6'h0a);
        measure(1'b1, n);
        check("2 hz first half", n > H2_CYC - TB_TICK && n <= H2_CYC,
            1'b1);
        measure(1'b1, n);
        check("2 hz half", n, H2_CYC);
        run_error = 1'b0;
        $display("test flash done");
        partner.send(6'h20);
        fatal_error = 1'b1;
        step(1);
        fatal_error = 1'b0;
        step(1);
        foreach (rows[i])
            partner.send(rows[i].req);
        step(200);
        check("fatal", {mode, lamp, app_execute}, {CMSL_MODE_FATAL, 2'h2,
            1'b0});
        $display("test fatal done");
        nrst = 1'b0;
        app_present = 1'b0;
        step(3);
        nrst = 1'b1;
        step(TB_SHOW + 10);
        check("no app", {mode, net_state, lamp}, {CMSL_MODE_STOP,
            CMSL_NET_PREPARED, 2'h1});
        $display("test no app done");
        nrst = 1'b0;
        os_present = 1'b0;
        step(3);
        check("second reset lamps", lamp, 2'h3);
        nrst = 1'b1;
        step(20);
        partner.send(6'h20);
        check("no os", {mode, lamp}, {CMSL_MODE_NO_OS, 2'h1});
        measure(1'b0, n);
        measure(1'b0, n);
        check("5 hz low half", n, H5_CYC);
        measure(1'b0, n);
        check("5 hz high half", n, H5_CYC);
        $display("test no os done");
        close_out();
    end
endmodule
